/* rtl/frs_regs.vh */
`ifndef FRS_REGS_VH
`define FRS_REGS_VH
// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define FRS_OFS_CTRL 12'h000
`define FRS_OFS_STATUS 12'h004
`define FRS_OFS_IRQ_STAT 12'h008
`define FRS_OFS_IRQ_MASK 12'h00c
`define FRS_OFS_OCP_CNT 12'h010
// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define FRS_CTRL_OCP_SEL_LO 0
`define FRS_CTRL_OCP_SEL_HI 1
`define FRS_CTRL_RETRY_SEL_LO 2
`define FRS_CTRL_RETRY_SEL_HI 3
`define FRS_CTRL_OCP_LATCH 4
`define FRS_CTRL_SCP_LATCH 5
`define FRS_CTRL_OVP_LATCH 6
`define FRS_CTRL_OTP_LATCH 7
`define FRS_CTRL_SCP_EN 8
`define FRS_CTRL_RESET 9'h000
// ----------------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------------
`define FRS_IRQ_RETRY 0
`define FRS_IRQ_LATCH 1
`define FRS_IRQ_THERM 2
`define FRS_IRQ_RESTART 3
`define FRS_IRQ_W 4
// ----------------------------------------------------------------------
// Timing and counts
// ----------------------------------------------------------------------
`define FRS_CLK_MHZ 200
`define FRS_RETRY0_MS 16'd200
`define FRS_RETRY1_MS 16'd400
`define FRS_RETRY2_MS 16'd800
`define FRS_RETRY3_MS 16'd1600
`define FRS_OCP0_K 16'd5
`define FRS_OCP1_K 16'd10
`define FRS_OCP2_K 16'd15
`define FRS_OCP3_K 16'd20
`define FRS_OCP_UP 2'd2
`define FRS_SCP_LIMIT 3'd5
`endif

/* rtl/frs_sync.v */
`timescale 1ns/100ps
// Two-flop synchroniser for a vector of comparator flags.
module frs_sync #(
  parameter W = 8
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Flags
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  // The first stage is read by the second stage alone.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // frs_sync

/* rtl/frs_ocp_counter.v */
`timescale 1ns/100ps
`include "frs_regs.vh"
// Up two on a tripped cycle, down one on a clean cycle, saturating.
module frs_ocp_counter #(
  parameter CW = 16
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Cycle events
  input wire cycle_end,
  input wire ocp_trip,
  input wire clear,
  input wire [CW-1:0] limit,
  // Result
  output reg [CW-1:0] count,
  output wire full
);
  wire [CW:0] up = {1'b0, count} + `FRS_OCP_UP;

  assign full = (count >= limit);

  // Updates once per switching cycle; clear zeroes it on any cycle.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= {CW{1'b0}};
    end else if (clear) begin
      count <= {CW{1'b0}};
    end else if (cycle_end) begin
      if (ocp_trip) begin
        count <= (up[CW:0] > {1'b0, limit}) ? limit : up[CW-1:0];
      end else if (count != {CW{1'b0}}) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // frs_ocp_counter

/* rtl/frs_top.v */
// Contract
// - Charge current off at supply-on while idle.
// - Charge current on at supply-off level.
// - Bias cycle until line gone, reset, timeout.
// - Auto fault: drives low, wait retry time.
// - After wait, soft start once supply on.
// - Latch fault ends drives at cycle end.
// - Latch in skip: no more pulses.
// - Latched: watch line, keep bias cycle (here the latch ignores line loss; only supply reset leaves it).
// - Over-temperature flag disables controller.
// - Stay off until hysteresis flag clears.
// - Reset level or line loss clears thermal.
// - Fresh power-up at next supply-on.
// - OCP count option 5/10/15/20 thousand.
// - OCP counter plus two, minus one.
// - SCP run over limit latches or restarts.
// - Latch released only by supply reset.
// - Per-fault latch or auto option.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "frs_regs.vh"
module frs_top #(
  parameter RETRY_SCALE = 32'd200000,
  parameter OCP_UNIT = 16'd1000
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Comparator and fault flags (asynchronous)
  input wire vcc_on,
  input wire vcc_off,
  input wire vcc_reset,
  input wire thermal_trip_point,
  input wire thermal_hysteresis,
  input wire line_removed,
  input wire fault_sense_input,
  input wire ovp_fault,
  input wire ocp_trip,
  input wire scp_trip,
  // Switching core flags (same clock)
  input wire cycle_end,
  input wire skip_mode,
  input wire clamp_flyback_mode,
  input wire pwm_main,
  input wire pwm_clamp,
  // Drives
  output reg main_gate_drive,
  output reg clamp_gate_drive,
  output reg startup_charge_current,
  output reg soft_start,
  output reg irq
);
  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  wire [9:0] s;
  frs_sync #(.W(10)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({scp_trip, ocp_trip, ovp_fault, fault_sense_input, line_removed,
        thermal_hysteresis, thermal_trip_point, vcc_reset, vcc_off,
        vcc_on}),
    .q(s)
  );
  wire s_on = s[0];
  wire s_off = s[1];
  wire s_rst = s[2];
  wire s_hot = s[3];
  wire s_cool = s[4];
  wire s_line = s[5];
  wire s_otp = s[6];
  wire s_ovp = s[7];
  wire s_ocp = s[8];
  wire s_scp = s[9];

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam ST_POWERUP = 5'b00001;
  localparam ST_RUN = 5'b00010;
  localparam ST_RETRY = 5'b00100;
  localparam ST_LATCH = 5'b01000;
  localparam ST_THERM = 5'b10000;

  reg [4:0] state;
  reg [4:0] next_state;
  reg [8:0] ctrl;
  reg [`FRS_IRQ_W-1:0] irq_stat;
  reg [`FRS_IRQ_W-1:0] irq_mask;
  reg [31:0] retry_cnt;
  reg [2:0] scp_cnt;
  reg latch_pend;
  reg [`FRS_IRQ_W-1:0] ev;

  // --------------------------------------------------------------------
  // Option decode
  // --------------------------------------------------------------------
  reg [15:0] ocp_k;
  reg [15:0] retry_ms;
  // Factory choices for count and retry wait.
  always @* begin
    case (ctrl[`FRS_CTRL_OCP_SEL_HI:`FRS_CTRL_OCP_SEL_LO])
      2'h0: ocp_k = `FRS_OCP0_K;
      2'h1: ocp_k = `FRS_OCP1_K;
      2'h2: ocp_k = `FRS_OCP2_K;
      default: ocp_k = `FRS_OCP3_K;
    endcase
    case (ctrl[`FRS_CTRL_RETRY_SEL_HI:`FRS_CTRL_RETRY_SEL_LO])
      2'h0: retry_ms = `FRS_RETRY0_MS;
      2'h1: retry_ms = `FRS_RETRY1_MS;
      2'h2: retry_ms = `FRS_RETRY2_MS;
      default: retry_ms = `FRS_RETRY3_MS;
    endcase
  end
  wire [31:0] ocp_prod = ocp_k * OCP_UNIT;
  wire [15:0] ocp_limit = ocp_prod[15:0];
  // Retry count stays a parameter so a bench can shrink it.
  wire [47:0] retry_prod = retry_ms * RETRY_SCALE;
  wire [31:0] retry_limit = retry_prod[31:0];

  // --------------------------------------------------------------------
  // Fault counters
  // --------------------------------------------------------------------
  wire ocp_full;
  wire [15:0] ocp_count;
  wire run = (state == ST_RUN);
  frs_ocp_counter #(.CW(16)) u_ocp (
    .hclk(hclk),
    .hresetn(hresetn),
    .cycle_end(cycle_end & run),
    .ocp_trip(s_ocp),
    .clear(~run),
    .limit(ocp_limit),
    .count(ocp_count),
    .full(ocp_full)
  );

  // Consecutive SCP events; a clean cycle restarts the run.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scp_cnt <= 3'h0;
    end else if (!run) begin
      scp_cnt <= 3'h0;
    end else if (cycle_end) begin
      scp_cnt <= s_scp ? ((scp_cnt == 3'h7) ? scp_cnt : scp_cnt + 3'h1)
                       : 3'h0;
    end
  end
  wire scp_over = ctrl[`FRS_CTRL_SCP_EN] &
                  (scp_cnt > `FRS_SCP_LIMIT);

  // Per-source reaction: latch or auto-recovery.
  wire f_ocp = ocp_full;
  wire f_scp = scp_over;
  wire any_fault = f_ocp | f_scp | s_ovp | s_otp;
  wire want_latch = (f_ocp & ctrl[`FRS_CTRL_OCP_LATCH]) |
                    (f_scp & ctrl[`FRS_CTRL_SCP_LATCH]) |
                    (s_ovp & ctrl[`FRS_CTRL_OVP_LATCH]) |
                    (s_otp & ctrl[`FRS_CTRL_OTP_LATCH]);
  wire retry_done = (retry_cnt >= retry_limit);

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_POWERUP: begin
        if (s_on) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (s_hot) begin
          next_state = ST_THERM;
        end else if (s_rst) begin
          next_state = ST_POWERUP;
        end else if (latch_pend && (cycle_end || skip_mode)) begin
          next_state = ST_LATCH;
        end else if (any_fault && !want_latch) begin
          next_state = ST_RETRY;
        end
      end
      ST_RETRY: begin
        if (s_rst || s_line) begin
          next_state = ST_POWERUP;
        end else if (retry_done && s_on) begin
          next_state = ST_RUN;
        end
      end
      ST_LATCH: begin
        if (s_rst) begin
          next_state = ST_POWERUP;
        end
      end
      ST_THERM: begin
        if (s_cool || s_rst || s_line) begin
          next_state = ST_POWERUP;
        end
      end
      default: next_state = ST_POWERUP;
    endcase
  end

  // State, retry timer and pending latch.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_POWERUP;
      retry_cnt <= 32'h0;
      latch_pend <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_RETRY && !retry_done) begin
        retry_cnt <= retry_cnt + 32'h1;
      end else if (state != ST_RETRY) begin
        retry_cnt <= 32'h0;
      end
      if (!run) begin
        latch_pend <= 1'b0;
      end else if (any_fault && want_latch) begin
        latch_pend <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Drives and bias cycle
  // --------------------------------------------------------------------
  wire bias = (state == ST_RETRY) || (state == ST_LATCH) ||
              (state == ST_THERM);
  wire drives_ok = (next_state == ST_RUN) && (state == ST_RUN);
  // Pulses pass only while running; a pending latch lets this cycle end outside skip mode.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_gate_drive <= 1'b0;
      clamp_gate_drive <= 1'b0;
      startup_charge_current <= 1'b0;
      soft_start <= 1'b0;
    end else begin
      main_gate_drive <= drives_ok & pwm_main &
                         ~(latch_pend & skip_mode);
      clamp_gate_drive <= drives_ok & pwm_clamp &
                          clamp_flyback_mode;
      soft_start <= (state != ST_RUN) && (next_state == ST_RUN);
      if (!bias) begin
        startup_charge_current <= (state == ST_POWERUP) && !s_on;
      end else if (s_on) begin
        startup_charge_current <= 1'b0;
      end else if (s_off) begin
        startup_charge_current <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt events
  // --------------------------------------------------------------------
  always @* begin
    ev = {`FRS_IRQ_W{1'b0}};
    ev[`FRS_IRQ_RETRY] = (state != ST_RETRY) && (next_state == ST_RETRY);
    ev[`FRS_IRQ_LATCH] = (state != ST_LATCH) && (next_state == ST_LATCH);
    ev[`FRS_IRQ_THERM] = (state != ST_THERM) && (next_state == ST_THERM);
    ev[`FRS_IRQ_RESTART] = (state == ST_RETRY) && (next_state == ST_RUN);
  end

  // --------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // --------------------------------------------------------------------
  reg wr_ph;
  reg [11:0] wr_addr;
  wire take = hsel & hready & htrans[1];
  // Write-one-to-clear loses to a same-cycle set.
  wire [`FRS_IRQ_W-1:0] w1c = (wr_ph && wr_addr == `FRS_OFS_IRQ_STAT) ?
                              hwdata[`FRS_IRQ_W-1:0] : {`FRS_IRQ_W{1'b0}};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      wr_addr <= 12'h000;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl <= `FRS_CTRL_RESET;
      irq_mask <= {`FRS_IRQ_W{1'b0}};
      irq_stat <= {`FRS_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      wr_ph <= take & hwrite;
      wr_addr <= haddr;
      if (take && !hwrite) begin
        case (haddr)
          `FRS_OFS_CTRL: hrdata <= {23'h0, ctrl};
          `FRS_OFS_STATUS: hrdata <= {21'h0, latch_pend, s[4:0], state};
          `FRS_OFS_IRQ_STAT: hrdata <= {28'h0, irq_stat};
          `FRS_OFS_IRQ_MASK: hrdata <= {28'h0, irq_mask};
          `FRS_OFS_OCP_CNT: hrdata <= {16'h0, ocp_count};
          default: hrdata <= 32'h0;
        endcase
      end
      if (wr_ph && wr_addr == `FRS_OFS_CTRL) begin
        ctrl <= hwdata[8:0];
      end
      if (wr_ph && wr_addr == `FRS_OFS_IRQ_MASK) begin
        irq_mask <= hwdata[`FRS_IRQ_W-1:0];
      end
      irq_stat <= (irq_stat & ~w1c) | ev;
      irq <= |(((irq_stat & ~w1c) | ev) & irq_mask);
    end
  end
endmodule // frs_top

/* testbench/frs_top_assertions.sv */
`timescale 1ns/100ps
// Port-level checks of the fault sequencer.
module frs_top_assertions (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Flags
  input wire vcc_on,
  input wire vcc_off,
  input wire vcc_reset,
  input wire thermal_trip_point,
  input wire thermal_hysteresis,
  input wire line_removed,
  input wire pwm_main,
  input wire pwm_clamp,
  // Drives
  input wire main_gate_drive,
  input wire clamp_gate_drive,
  input wire startup_charge_current,
  input wire soft_start
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Causes
  // ----------------------------------------------------------------
  // The charge may also stop when the line goes away.
  wire stop_cause = vcc_on | line_removed;
  // Line loss sends the sequencer from retry or thermal back to power-up, which charges.
  wire go_cause = vcc_off | vcc_reset | thermal_hysteresis |
                  line_removed;
  sequence s_hot;
    thermal_trip_point [*6];
  endsequence
  sequence s_rd_hole;
    hsel && hready && htrans[1] && !hwrite && haddr == 12'h040;
  endsequence
  hot_off_a: assert property (s_hot |-> !main_gate_drive && !clamp_gate_drive)
    else $error("drive active while hot");
  main_gated_a: assert property (main_gate_drive |-> $past(pwm_main))
    else $error("main drive without pwm");
  clamp_gated_a: assert property (clamp_gate_drive |-> $past(pwm_clamp))
    else $error("clamp drive without pwm");
  chg_off_a: assert property ($fell(startup_charge_current) |->
    $past(stop_cause, 2) || $past(stop_cause, 3) || $past(stop_cause, 4))
    else $error("charge stopped without cause");
  chg_on_a: assert property ($rose(startup_charge_current) |->
    $past(go_cause, 2) || $past(go_cause, 3) || $past(go_cause, 4))
    else $error("charge started without cause");
  ss_on_a: assert property (soft_start |->
    $past(vcc_on, 2) || $past(vcc_on, 3) || $past(vcc_on, 4))
    else $error("soft start without supply");
  ss_pulse_a: assert property (soft_start |=> !soft_start [*8])
    else $error("soft start not a pulse");
  run_nochg_a: assert property (main_gate_drive |-> !startup_charge_current)
    else $error("charging while switching");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus wait or error");
  hole_zero_a: assert property (s_rd_hole |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // frs_top_assertions

/* testbench/frs_plant.sv */
`timescale 1ns/100ps
// Supply capacitor, comparators and switching core at the far side.
module frs_plant (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // From block and bench
  input wire startup_charge_current,
  input wire main_gate_drive,
  input wire unplug,
  // Comparators and core
  output wire vcc_on,
  output wire vcc_off,
  output wire vcc_reset,
  output wire cycle_end,
  output wire pwm_main,
  output wire pwm_clamp
);
  reg [7:0] lvl;
  reg [2:0] ph;
  reg [4:0] aux;
  // Slow decay keeps the on flag up past the sync latency.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl <= 8'h00;
      ph <= 3'h0;
      aux <= 5'h00;
    end else begin
      ph <= ph + 3'h1;
      aux <= main_gate_drive ? 5'h1f : aux - (aux != 5'h00);
      if (unplug)
        lvl <= (lvl > 8'h02) ? lvl - 8'h02 : 8'h00;
      else if (startup_charge_current && lvl < 8'hc8)
        lvl <= lvl + 8'h01;
      else if (aux == 5'h00 && ph == 3'h7 && lvl != 8'h00)
        lvl <= lvl - 8'h01;
    end
  end
  // Comparator levels, with a wide band for the bias cycle.
  assign vcc_on = lvl >= 8'h78;
  assign vcc_off = lvl <= 8'h28;
  assign vcc_reset = lvl <= 8'h08;
  assign cycle_end = ph == 3'h7;
  assign pwm_main = ph < 3'h3;
  assign pwm_clamp = ph == 3'h5;
endmodule // frs_plant

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`include "frs_regs.vh"
module tb_top;
  reg hclk, hresetn, hsel, hwrite, unplug, ovp_fault, ocp_trip;
  reg thermal_trip_point, thermal_hysteresis;
  reg skip_mode, scp_trip;
  reg [11:0] haddr;
  reg [1:0] htrans;
  reg [31:0] hwdata;
  wire [31:0] hrdata;
  wire hready, hresp, vcc_on, vcc_off, vcc_reset, cycle_end, pwm_main;
  wire pwm_clamp, main_gate_drive, clamp_gate_drive, chg, soft_start, irq;
  integer errors, num_checks, cyc, t0, n, rises;
  reg chg_q;
  reg [31:0] q;
  frs_top #(.RETRY_SCALE(32'd10), .OCP_UNIT(16'd1)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .vcc_on(vcc_on), .vcc_off(vcc_off), .vcc_reset(vcc_reset),
    .thermal_trip_point(thermal_trip_point),
    .thermal_hysteresis(thermal_hysteresis), .line_removed(unplug),
    .fault_sense_input(1'b0), .ovp_fault(ovp_fault), .ocp_trip(ocp_trip),
    .scp_trip(scp_trip), .cycle_end(cycle_end), .skip_mode(skip_mode),
    .clamp_flyback_mode(1'b1), .pwm_main(pwm_main), .pwm_clamp(pwm_clamp),
    .main_gate_drive(main_gate_drive), .clamp_gate_drive(clamp_gate_drive),
    .startup_charge_current(chg), .soft_start(soft_start), .irq(irq));
  frs_plant i_plant (.hclk(hclk), .hresetn(hresetn),
    .startup_charge_current(chg), .main_gate_drive(main_gate_drive),
    .unplug(unplug), .vcc_on(vcc_on), .vcc_off(vcc_off),
    .vcc_reset(vcc_reset), .cycle_end(cycle_end), .pwm_main(pwm_main),
    .pwm_clamp(pwm_clamp));
  // ----------------------------------------------------------------
  // Clock, timeout and charge-pulse counter
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // The run needs about 7k cycles; the ceiling leaves margin.
  always @(posedge hclk) begin
    cyc = cyc + 1;
    rises = rises + (chg === 1'b1 && chg_q !== 1'b1);
    chg_q = chg;
    if (cyc == 30000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
    end
  endtask
  task rdm(input [11:0] a, input [31:0] m, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
    end
  endtask
  task wait_ss(input integer lim);
    begin
      n = 0;
      while (soft_start !== 1'b1 && n < lim) begin
        @(negedge hclk);
        n = n + 1;
      end
      chk(soft_start, 1'b1);
    end
  endtask
  // Pull the line until the supply collapses, then restore it.
  task replug;
    begin
      @(posedge hclk);
      unplug <= 1'b1;
      repeat (200) @(posedge hclk);
      unplug <= 1'b0;
      wait_ss(1000);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, unplug, ovp_fault, ocp_trip} = 6'h00;
    {thermal_trip_point, thermal_hysteresis, haddr, htrans} = 16'h0;
    hwdata = 32'h0;
    {skip_mode, scp_trip} = 2'h0;
    {errors, num_checks, cyc, rises} = 128'h0;
    chg_q = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdm(`FRS_OFS_CTRL, 32'hffffffff, 32'h0);
    rdm(`FRS_OFS_IRQ_MASK, 32'hffffffff, 32'h0);
    rdm(12'h040, 32'hffffffff, 32'h0);
    wait_ss(1000);
    rdm(`FRS_OFS_STATUS, 32'h1f, 32'h2);
    bus(1'b1, `FRS_OFS_IRQ_MASK, 32'hf);
    // Auto-recovery fault: off for the retry time, bias cycle meanwhile.
    t0 = cyc;
    rises = 0;
    ovp_fault <= 1'b1;
    repeat (20) @(posedge hclk);
    ovp_fault <= 1'b0;
    rdm(`FRS_OFS_STATUS, 32'h1f, 32'h4);
    chk(main_gate_drive | clamp_gate_drive, 1'b0);
    chk(irq, 1'b1);
    rdm(`FRS_OFS_IRQ_STAT, 32'h1, 32'h1);
    bus(1'b1, `FRS_OFS_IRQ_STAT, 32'h1);
    repeat (3) @(negedge hclk);
    chk(irq, 1'b0);
    wait_ss(4000);
    chk((cyc - t0) >= 200 * 10, 1'b1);
    chk(rises >= 2, 1'b1);
    rdm(`FRS_OFS_IRQ_STAT, 32'h8, 32'h8);
    // Latching fault: stays off through bias cycles until supply reset.
    bus(1'b1, `FRS_OFS_CTRL, 32'h40);
    rises = 0;
    ovp_fault <= 1'b1;
    repeat (20) @(posedge hclk);
    ovp_fault <= 1'b0;
    repeat (3000) @(negedge hclk);
    rdm(`FRS_OFS_STATUS, 32'h1f, 32'h8);
    chk(main_gate_drive | clamp_gate_drive, 1'b0);
    chk(rises >= 2, 1'b1);
    replug;
    // Thermal: held off after the trip clears until cooled.
    thermal_trip_point <= 1'b1;
    repeat (20) @(posedge hclk);
    thermal_trip_point <= 1'b0;
    rdm(`FRS_OFS_STATUS, 32'h1f, 32'h10);
    chk(main_gate_drive | clamp_gate_drive, 1'b0);
    repeat (400) @(posedge hclk);
    rdm(`FRS_OFS_STATUS, 32'h1f, 32'h10);
    thermal_hysteresis <= 1'b1;
    wait_ss(2000);
    @(posedge hclk);
    thermal_hysteresis <= 1'b0;
    thermal_trip_point <= 1'b1;
    repeat (20) @(posedge hclk);
    thermal_trip_point <= 1'b0;
    // Line loss clears thermal shutdown well above the reset level.
    unplug <= 1'b1;
    repeat (10) @(posedge hclk);
    unplug <= 1'b0;
    rdm(`FRS_OFS_STATUS, 32'h10, 32'h0);
    replug;
    // Latching short circuit while skipping: latched, no pulses.
    bus(1'b1, `FRS_OFS_CTRL, 32'h120);
    skip_mode <= 1'b1;
    scp_trip <= 1'b1;
    repeat (100) @(posedge hclk);
    scp_trip <= 1'b0;
    rdm(`FRS_OFS_STATUS, 32'h1f, 32'h8);
    chk(main_gate_drive | clamp_gate_drive, 1'b0);
    skip_mode <= 1'b0;
    replug;
    // Overcurrent: limit of five with the unit scaled to one.
    bus(1'b1, `FRS_OFS_CTRL, 32'h0);
    ocp_trip <= 1'b1;
    repeat (100) @(posedge hclk);
    ocp_trip <= 1'b0;
    rdm(`FRS_OFS_STATUS, 32'h1f, 32'h4);
    report_and_stop;
  end
endmodule // tb_top
bind frs_top frs_top_assertions i_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .vcc_on,
  .vcc_off, .vcc_reset, .thermal_trip_point, .thermal_hysteresis,
  .line_removed, .pwm_main, .pwm_clamp, .main_gate_drive,
  .clamp_gate_drive, .startup_charge_current, .soft_start);
